/* verif/fcw_flash_model.sv */
// Purpose: behavioural byte-wide flash seen from its pins
// Assumes: no clock; the model reacts to its own pin edges
// Notes: released data lines show the inverse of the last byte
`include "fcw_regs.svh"
`default_nettype none
module fcw_flash_model (
  input wire logic sel_n_in, // Device select, low
  input wire logic gate_n_in, // Output gate, low
  input wire logic wr_n_in, // Write strobe, low
  input wire logic vpp_cmd_n_in, // Low = high supply
  input wire logic [14:0] address_lines_in, // Address
  input wire logic [7:0] data_lines_in, // Bus as seen
  output logic [7:0] data_lines_out, // Byte to host
  output logic drive_out, // High while driving
  output logic [14:0] cmd_addr_out, // Latched address
  output logic [7:0] cmd_data_out, // Latched byte
  output int wr_cnt_out, // Taken writes
  output logic read_mode_out // High while in read mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:32767];
  logic [7:0] last_q = 8'h00;
  logic open_q = 1'b0;
  logic read_mode_q = 1'b1;
  // ****
  // Array contents and command latches
  // ****
  initial begin
    cmd_addr_out = '0;
    cmd_data_out = '0;
    wr_cnt_out = 0;
    for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ {1'b0, i[14:8]};
  end
  // Address at the later fall; no cycle opens without high supply
  always @(negedge wr_n_in or negedge sel_n_in) begin
    if (!wr_n_in && !sel_n_in && gate_n_in && !vpp_cmd_n_in) begin
      cmd_addr_out <= address_lines_in;
      open_q <= 1'b1;
    end
  end
  // Data at the first rise; the byte feeds the mode logic
  always @(posedge wr_n_in or posedge sel_n_in) begin
    if (open_q) begin
      cmd_data_out <= data_lines_in;
      wr_cnt_out <= wr_cnt_out + 1;
      read_mode_q <= !(data_lines_in inside {`FCW_CMD_SETUP_ERASE, `FCW_CMD_SETUP_PROG,
        `FCW_CMD_ERASE_VERIFY, `FCW_CMD_PROG_VERIFY});
      open_q <= 1'b0;
    end
  end
  // Mode seen by the bench, so an undefined byte can be judged
  assign read_mode_out = read_mode_q;
  // Drive only with gate low, else show a changed stale value
  assign drive_out = !sel_n_in && !gate_n_in && wr_n_in;
  always @* begin
    if (drive_out) data_lines_out = mem[address_lines_in];
    else data_lines_out = ~last_q;
  end
  always @(data_lines_out) if (drive_out) last_q = data_lines_out;
endmodule : fcw_flash_model
`default_nettype wire

/* verif/flash_command_write_port_test.sv */
// Purpose: self-checking bench for the flash command write host
// Assumes: 50 MHz clock, short pulse counts in simulation
// Notes: latency counted in cycles from the take edge
`include "fcw_regs.svh"
`default_nettype none
module flash_command_write_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG_N = 10;
  localparam int ERASE_N = 20;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, done, vpp_cmd_n, oe_n, dev_drv, rd_mode;
  fcw_pkg::fcw_req_s req = '0;
  fcw_pkg::fcw_ctl_s ctl;
  logic [7:0] rd_data, host_dq, dev_dq, bus_dq, cmd_data;
  logic [14:0] cmd_addr;
  int wr_cnt;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  // ****
  // Clock, bus and instances
  // ****
  always #10 ref_clk_in = ~ref_clk_in;
  assign bus_dq = oe_n ? dev_dq : host_dq; // Host wins only while enabled
  fcw_host #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) u_dut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_in(req), .done_out(done), .rd_data_out(rd_data),
    .vpp_cmd_n_out(vpp_cmd_n), .ctl_out(ctl), .data_lines_out(host_dq),
    .data_lines_oe_n_out(oe_n), .data_lines_in(bus_dq));
  fcw_flash_model u_flash (
    .sel_n_in(ctl.sel_n), .gate_n_in(ctl.gate_n), .wr_n_in(ctl.wr_n),
    .vpp_cmd_n_in(vpp_cmd_n), .address_lines_in(ctl.address_lines),
    .data_lines_in(bus_dq), .data_lines_out(dev_dq), .drive_out(dev_drv),
    .cmd_addr_out(cmd_addr), .cmd_data_out(cmd_data), .wr_cnt_out(wr_cnt),
    .read_mode_out(rd_mode));
  // ****
  // Tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // One request; ready is read after the combinational path settles
  task automatic do_req(input fcw_pkg::fcw_op_e op, input logic [14:0] a,
    input logic [7:0] d, output int lat);
    @(negedge ref_clk_in);
    req = '{op, a, d};
    req_valid = 1'b1;
    #1;
    while (req_ready !== 1'b1) begin
      @(negedge ref_clk_in);
      #1;
    end
    @(negedge ref_clk_in);
    req_valid = 1'b0;
    lat = 0;
    while (done !== 1'b1) begin
      check({15'h0, dev_drv & ~oe_n}, 16'h0);
      @(negedge ref_clk_in);
      lat++;
    end
  endtask : do_req
  task automatic t_reset();
    check({ctl.sel_n, ctl.gate_n, ctl.wr_n, oe_n, vpp_cmd_n, done}, 16'h3e);
  endtask : t_reset
  task automatic t_read(input logic [14:0] a);
    int lat;
    do_req(fcw_pkg::FCW_OP_READ, a, 8'h00, lat);
    check(16'(lat), 16'(`FCW_READ_CYCLES + 1));
    check({8'h0, rd_data}, {8'h0, a[7:0] ^ {1'b0, a[14:8]}});
  endtask : t_read
  task automatic t_write(input logic [14:0] a, input logic [7:0] d);
    int lat;
    int n;
    logic exp_mode;
    n = wr_cnt;
    // Only the four setup and verify command bytes leave read mode
    exp_mode = !(d inside {`FCW_CMD_SETUP_ERASE, `FCW_CMD_SETUP_PROG,
      `FCW_CMD_ERASE_VERIFY, `FCW_CMD_PROG_VERIFY});
    do_req(fcw_pkg::FCW_OP_WRITE, a, d, lat);
    check(16'(lat), 16'(`FCW_SETUP_CYCLES + `FCW_STROBE_CYCLES + 2));
    check({15'h0, rd_mode}, {15'h0, exp_mode});
    check({1'b0, cmd_addr}, {1'b0, a});
    check({8'h0, cmd_data}, {8'h0, d});
    check(16'(wr_cnt), 16'(n + 1));
  endtask : t_write
  task automatic t_pulse(input fcw_pkg::fcw_op_e op, input int n);
    int lat;
    do_req(op, 15'h0, 8'h00, lat);
    check(16'(lat), 16'(n + 1));
  endtask : t_pulse
  // Supply must drop once nothing is pending
  task automatic t_idle();
    for (int i = 0; i < 100 && vpp_cmd_n !== 1'b1; i++) @(negedge ref_clk_in);
    check({15'h0, vpp_cmd_n}, 16'h1);
  endtask : t_idle
  // ****
  // Main sequence and hang guard
  // ****
  initial begin
    repeat (10) @(negedge ref_clk_in);
    t_reset();
    reset_n_in = 1'b1;
    t_read(15'h0000);
    t_read(15'h7fff);
    t_write(15'h1234, `FCW_CMD_SETUP_PROG);
    t_write(15'h7fff, 8'ha5);
    t_pulse(fcw_pkg::FCW_OP_PROG_PULSE, PROG_N);
    t_write(15'h0000, `FCW_CMD_SETUP_ERASE);
    t_write(15'h0000, `FCW_CMD_SETUP_ERASE);
    t_pulse(fcw_pkg::FCW_OP_ERASE_PULSE, ERASE_N);
    t_write(15'h0001, 8'h55); // Undefined byte, back to reading
    t_read(15'h0001);
    t_idle();
    conclude();
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      conclude();
    end
  end
endmodule : flash_command_write_port_test
`default_nettype wire

/* verilog/fcw_host.sv */
// Purpose: host controller driving a byte-wide flash over its strobe pins
// Assumes: 50 MHz clock; device has no clock or reset of its own
// Notes: one request at a time; pulse timing is counted here
//
// How it works
// R1 - device latches address at later falling edge
// R2 - device latches data at earlier rising edge
// R3 - writes may be strobe or select controlled
// R4 - device holds latched address and data
// R5 - latched command drives device state machine
// R6 - program pulse timed 10 us by host
// R7 - erase pulse timed 10 ms by host
// R8 - 32K byte-wide locations addressed
// R9 - separate select and gate avoid contention
// R10 - supply command low requests high voltage
// R11 - write timing referenced to write strobe
// R12 - commands accepted only with high supply
// R13 - command needs select low, gate high, strobe low
// R14 - undefined command aborts to read mode
// R15 - read drives byte with gate low
`include "fcw_regs.svh"
`default_nettype none
module fcw_host #(
  parameter int ERASE_CYCLES = `FCW_ERASE_CYCLES,
  parameter int PROG_CYCLES = `FCW_PROG_CYCLES,
  parameter int ADDR_W = 15,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_in, // 50 MHz clock
  input wire logic reset_n_in, // Async reset, low
  input wire logic req_valid_in, // Request present
  output logic req_ready_out, // Request can be taken this cycle
  input wire fcw_pkg::fcw_req_s req_in, // Operation, address, data
  output logic done_out, // Pulse: request finished
  output logic [DATA_W-1:0] rd_data_out, // Byte read back
  output logic vpp_cmd_n_out, // Supply command, low = high voltage
  output fcw_pkg::fcw_ctl_s ctl_out, // Select, gate, strobe, address
  output logic [DATA_W-1:0] data_lines_out, // Data driven to device
  output logic data_lines_oe_n_out, // Low while host drives data
  input wire logic [DATA_W-1:0] data_lines_in // Data from device
);
  // ****************************************
  // State and registers
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD = 3'b011,
    ST_READ = 3'b100,
    ST_PULSE = 3'b101,
    ST_DONE = 3'b110
  } fcw_st_e;
  fcw_st_e st_q;
  fcw_pkg::fcw_req_s cur_q;
  logic [31:0] cnt_q;
  logic [DATA_W-1:0] rd_sync;
  logic vpp_on_q;
  logic [4:0] settle_q;
  logic settled;

  fcw_sync #(.W(DATA_W)) u_sync (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .d_in(data_lines_in),
    .q_out(rd_sync)
  );

  assign settled = (settle_q == 5'(`FCW_VPP_SETTLE_CYCLES));
  // Writes wait for supply to settle; reads never need it
  assign req_ready_out = (st_q == ST_IDLE) &&
    ((req_in.op == fcw_pkg::FCW_OP_READ) || settled); // R12

  // ****************************************
  // Supply command
  // ****************************************
  // High voltage only while a write or pulse is pending or running
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vpp_on_q <= 1'b0;
    end else begin
      vpp_on_q <= req_valid_in && (req_in.op != fcw_pkg::FCW_OP_READ) ||
        (st_q != ST_IDLE && cur_q.op != fcw_pkg::FCW_OP_READ); // R10
    end
  end
  assign vpp_cmd_n_out = !vpp_on_q; // R10

  // Settling time after supply request
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      settle_q <= '0;
    end else if (!vpp_on_q) begin
      settle_q <= '0;
    end else if (!settled) begin
      settle_q <= settle_q + 5'd1;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= ST_IDLE;
      cur_q <= '0;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (req_valid_in && req_ready_out) begin
            cur_q <= req_in;
            unique case (req_in.op)
              fcw_pkg::FCW_OP_READ: st_q <= ST_READ; // R15
              fcw_pkg::FCW_OP_WRITE: st_q <= ST_SETUP;
              default: st_q <= ST_PULSE; // R6 R7
            endcase
          end
        end
        // Address settles before strobe falls
        ST_SETUP: begin
          cnt_q <= cnt_q + 32'd1;
          if (cnt_q == 32'(`FCW_SETUP_CYCLES - 1)) begin
            cnt_q <= '0;
            st_q <= ST_STROBE;
          end
        end
        // Strobe low; device latches address at its fall
        ST_STROBE: begin
          cnt_q <= cnt_q + 32'd1;
          if (cnt_q == 32'(`FCW_STROBE_CYCLES - 1)) begin
            cnt_q <= '0;
            st_q <= ST_HOLD; // R2
          end
        end
        // Data held one cycle after strobe rises
        ST_HOLD: st_q <= ST_DONE; // R11
        ST_READ: begin
          cnt_q <= cnt_q + 32'd1;
          if (cnt_q == 32'(`FCW_READ_CYCLES - 1)) begin
            st_q <= ST_DONE;
          end
        end
        // Host times the pulse; reaching the erase or program count ends it
        ST_PULSE: begin
          cnt_q <= cnt_q + 32'd1;
          if (cnt_q == ((cur_q.op == fcw_pkg::FCW_OP_ERASE_PULSE) ?
              32'(ERASE_CYCLES - 1) : 32'(PROG_CYCLES - 1))) begin
            st_q <= ST_DONE; // R6 R7
          end
        end
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  // Strobe-controlled write: select low across strobe, gate high
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_out <= '{sel_n: 1'b1, gate_n: 1'b1, wr_n: 1'b1, address_lines: '0};
      data_lines_out <= '0;
      data_lines_oe_n_out <= 1'b1;
    end else begin
      ctl_out.address_lines <= cur_q.addr; // R8
      data_lines_out <= cur_q.data;
      ctl_out.sel_n <= !(st_q == ST_SETUP || st_q == ST_STROBE || st_q == ST_HOLD
        || st_q == ST_READ); // R3
      ctl_out.gate_n <= (st_q != ST_READ); // R9 R15
      ctl_out.wr_n <= (st_q != ST_STROBE); // R1 R13
      data_lines_oe_n_out <= !(st_q == ST_SETUP || st_q == ST_STROBE ||
        st_q == ST_HOLD); // R9
    end
  end

  // Read data captured at end of read window
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= (st_q == ST_DONE);
      if (st_q == ST_READ && cnt_q == 32'(`FCW_READ_CYCLES - 1)) begin
        rd_data_out <= rd_sync; // R15
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_wr_gate;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      !ctl_out.wr_n |-> (!ctl_out.sel_n && ctl_out.gate_n);
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("strobe low without select"); // R13
  property p_no_fight;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      !ctl_out.gate_n |-> data_lines_oe_n_out;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus contention"); // R9
  property p_vpp_wr;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      !ctl_out.wr_n |-> !vpp_cmd_n_out;
  endproperty
  a_vpp_wr: assert property (p_vpp_wr) else $error("write without supply"); // R12
  sequence s_strobe;
    !ctl_out.wr_n [*3];
  endsequence
  property p_strobe_len;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $fell(ctl_out.wr_n) |-> s_strobe ##1 ctl_out.wr_n;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong"); // R11
  property p_data_hold;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(ctl_out.wr_n) |-> !data_lines_oe_n_out && $stable(data_lines_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held"); // R2
  property p_addr_set;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $fell(ctl_out.wr_n) |-> !ctl_out.sel_n && $stable(ctl_out.address_lines);
  endproperty
  a_addr_set: assert property (p_addr_set) else $error("address moved"); // R1
  property p_prog_len;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (st_q == ST_IDLE && req_valid_in && req_ready_out &&
       req_in.op == fcw_pkg::FCW_OP_PROG_PULSE) |=> (st_q == ST_PULSE) [*8];
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("program pulse short"); // R6
  property p_vpp_idle;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (st_q == ST_IDLE && !req_valid_in) ##1 (st_q == ST_IDLE && !req_valid_in)
        |-> vpp_cmd_n_out;
  endproperty
  a_vpp_idle: assert property (p_vpp_idle) else $error("supply left on"); // R10
  property p_erase_run;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (st_q == ST_PULSE && cur_q.op == fcw_pkg::FCW_OP_ERASE_PULSE &&
       cnt_q < 32'(ERASE_CYCLES - 1)) |=> (st_q == ST_PULSE);
  endproperty
  a_erase_run: assert property (p_erase_run) else $error("erase pulse short"); // R7
endmodule : fcw_host
`default_nettype wire

/* verilog/fcw_pkg.sv */
// Purpose: types shared by the flash command write host controller
// Assumes: 32K x 8 array
// Notes: pin and request groups travel as packed structs
`default_nettype none
package fcw_pkg;
  typedef enum logic [1:0] {
    FCW_OP_READ = 2'b00,
    FCW_OP_WRITE = 2'b01,
    FCW_OP_PROG_PULSE = 2'b10,
    FCW_OP_ERASE_PULSE = 2'b11
  } fcw_op_e;
  typedef struct packed {
    fcw_op_e op;
    logic [14:0] addr;
    logic [7:0] data;
  } fcw_req_s;
  typedef struct packed {
    logic sel_n;
    logic gate_n;
    logic wr_n;
    logic [14:0] address_lines;
  } fcw_ctl_s;
endpackage : fcw_pkg
`default_nettype wire

/* verilog/fcw_regs.svh */
// Purpose: constants for the flash command write host controller
// Assumes: 50 MHz reference clock
// Notes: pulse cycle counts derived from the printed pulse widths
`ifndef FCW_REGS_SVH
`define FCW_REGS_SVH
`define FCW_CLK_MHZ 50
`define FCW_PROG_PULSE_US 10
`define FCW_ERASE_PULSE_MS 10
`define FCW_PROG_CYCLES (`FCW_PROG_PULSE_US * `FCW_CLK_MHZ)
`define FCW_ERASE_CYCLES (`FCW_ERASE_PULSE_MS * 1000 * `FCW_CLK_MHZ)
`define FCW_SETUP_CYCLES 2
`define FCW_STROBE_CYCLES 3
`define FCW_READ_CYCLES 6
`define FCW_VPP_SETTLE_CYCLES 16
`define FCW_CMD_SETUP_ERASE 8'h20
`define FCW_CMD_SETUP_PROG 8'h40
`define FCW_CMD_ERASE_VERIFY 8'ha0
`define FCW_CMD_PROG_VERIFY 8'hc0
`define FCW_CMD_READ 8'h00
`endif

/* verilog/fcw_sync.sv */
// Purpose: two-flop synchroniser for the returned data lines
// Assumes: destination is ref_clk_in
// Notes: first stage feeds only the second stage
`default_nettype none
module fcw_sync #(
  parameter int W = 8
) (
  input wire logic ref_clk_in, // Clock
  input wire logic reset_n_in, // Async reset, low
  input wire logic [W-1:0] d_in, // Asynchronous level
  output logic [W-1:0] q_out // Synchronised level
);
  logic [W-1:0] meta_q;
  // Two stages, meta then output
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule : fcw_sync
`default_nettype wire
